// file: src/icot_timer.sv
// free running timer with three input captures and an overflow flag
// Function
// - one shared free-running 16-bit counter for all channels.
// - counter advances once per timer tick, one count per 500 ns.
// - counter wrap sets overflow flag; it stays until software clears.
// - selected edge latches counter and sets capture flag, independent of overflow.
// - overflow interrupt ranks below every capture interrupt.
// - three captures work independently on the one counter and overflow.
// - edge select 0:1 on channel 1 captures rising edges only.
// - writing one to flags-2 bit 7 clears overflow; zero leaves it.
// - mask-1 bit 2 enables channel 1 capture interrupt.
// - mask-2 bit 7 enables overflow interrupt.
// - writing one to flags-1 bit 2 clears channel 1 flag; zeros untouched.
`timescale 1ns/10ps
`default_nettype none
`include "icot_map.svh"
module icot_timer (
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic [2:0]             capture_pin,
  input  wire logic [7:0]             timer_control_2,
  input  wire logic [7:0]             timer_int_mask_1,
  input  wire logic [7:0]             timer_int_mask_2,
  input  wire logic                   flags_1_wr,
  input  wire logic [7:0]             flags_1_wdata,
  input  wire logic                   flags_2_wr,
  input  wire logic [7:0]             flags_2_wdata,
  output logic [`ICOT_CNT_W-1:0]      timer_count,
  output logic [`ICOT_CNT_W-1:0]      capture_value_1,
  output logic [`ICOT_CNT_W-1:0]      capture_value_2,
  output logic [`ICOT_CNT_W-1:0]      capture_value_3,
  output logic [7:0]                  timer_flags_1,
  output logic [7:0]                  timer_flags_2,
  output logic                        irq_req,
  output logic [1:0]                  irq_source
);
  localparam logic [`ICOT_TICK_W-1:0] TICK_LAST = `ICOT_TICK_W'(`ICOT_TICK_CYC - 1);

  icot_pkg::icot_state_t st_reg;
  icot_pkg::icot_state_t st_next;
  logic [2:0]            hit;
  logic [2:0]            ic_clr;
  logic [2:0]            ic_en;
  logic [2:0]            icf_set;
  logic [2:0]            icf_clr;
  logic [`ICOT_CNT_W-1:0] cap [3];
  logic                  tick;
  logic                  wrap;
  logic                  tof_clr;

  genvar gi;
  generate
    for (gi = 0; gi < `ICOT_NUM_IC; gi = gi + 1) begin : g_ic
      icot_capture_ch u_ch (
        .clk_sys       (clk_sys),
        .nrst          (nrst),
        .ce            (ce),
        .edge_sel      (timer_control_2[`ICOT_EDG1_LO_BIT-2*gi+1 -: 2]),
        .pin_now       (capture_pin[gi]),
        .pin_prev      (st_reg.pin_reg[gi]),
        .count         (st_reg.count_reg),
        .hit           (hit[gi]),
        .capture_value (cap[gi])
      );
      // channel flags live at bits 2,1,0 of flags 1, enables likewise in mask 1
      assign ic_clr[gi] = flags_1_wr & flags_1_wdata[`ICOT_CAPTURE1_FLAG_BIT-gi];
      assign ic_en[gi]  = timer_int_mask_1[`ICOT_IC1_MASK_BIT-gi];
      // flag bit of channel gi sits at the same position as its clear bit
      assign icf_set[`ICOT_CAPTURE1_FLAG_BIT-gi] = hit[gi];
      assign icf_clr[`ICOT_CAPTURE1_FLAG_BIT-gi] = ic_clr[gi];
    end
  endgenerate

  // one count per 500 ns with divide-by-one prescale
  assign tick = (st_reg.tick_reg == TICK_LAST);
  assign wrap = tick && (st_reg.count_reg == `ICOT_CNT_MAX);
  // only a one in bit 7 clears the overflow flag
  assign tof_clr = flags_2_wr & flags_2_wdata[`ICOT_TOF_BIT];

  always_comb begin
    st_next = st_reg;
    st_next.pin_reg = capture_pin;
    st_next.tick_reg = tick ? '0 : st_reg.tick_reg + `ICOT_TICK_W'(1);
    // counter free-runs regardless of captures and clears
    if (tick) begin
      st_next.count_reg = st_reg.count_reg + `ICOT_CNT_ONE;
    end
    // wrap sets flag, set wins over clear
    st_next.tof_reg = wrap | (st_reg.tof_reg & ~tof_clr);
    st_next.icf_reg = icf_set | (st_reg.icf_reg & ~icf_clr);
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign timer_count     = st_reg.count_reg;
  assign capture_value_1 = cap[0];
  assign capture_value_2 = cap[1];
  assign capture_value_3 = cap[2];
  assign timer_flags_1   = {5'h00, st_reg.icf_reg};
  assign timer_flags_2   = {st_reg.tof_reg, 7'h00};

  // captures ranked above overflow; channel 1 highest
  always_comb begin
    irq_req    = 1'b0;
    irq_source = 2'h0;
    if (st_reg.icf_reg[2] && ic_en[0]) begin
      irq_req    = 1'b1;
      irq_source = 2'h1;
    end else if (st_reg.icf_reg[1] && ic_en[1]) begin
      irq_req    = 1'b1;
      irq_source = 2'h2;
    end else if (st_reg.icf_reg[0] && ic_en[2]) begin
      irq_req    = 1'b1;
      irq_source = 2'h3;
    end else if (st_reg.tof_reg && timer_int_mask_2[`ICOT_TOI_BIT]) begin
      irq_req    = 1'b1;
      irq_source = 2'h0;
    end
  end

  tick_period_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && tick) |=> (st_reg.tick_reg == 5'h00) ##0 (!tick [*1]))
    else $error("timer tick period wrong");
  count_step_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && tick) |=> (st_reg.count_reg == $past(st_reg.count_reg) + 16'h0001))
    else $error("counter did not advance on tick");
  count_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && !tick) |=> $stable(st_reg.count_reg))
    else $error("counter moved without tick");
  tof_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && wrap) |=> (timer_flags_2[7] && timer_count == 16'h0000))
    else $error("overflow flag not set on wrap");
  tof_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && st_reg.tof_reg && !wrap && flags_2_wr && !flags_2_wdata[7]) |=> st_reg.tof_reg)
    else $error("overflow flag cleared by zero write");
  rise_only_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && timer_control_2[5:4] == 2'b01 && !capture_pin[0] && st_reg.pin_reg[0]
      && !st_reg.icf_reg[2]) |=> !st_reg.icf_reg[2])
    else $error("channel 1 captured on falling edge");
  ic1_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && hit[0]) |=> (timer_flags_1[2] && capture_value_1 == $past(timer_count)))
    else $error("channel 1 flag or value missing");
  ic1_clear_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && flags_1_wr && flags_1_wdata[2] && !hit[0]) |=> !timer_flags_1[2])
    else $error("channel 1 flag not cleared");
  ic1_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (timer_flags_1[2] && timer_int_mask_1[2]) |-> (irq_req && irq_source == 2'h1))
    else $error("channel 1 interrupt missing");
  tof_irq_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (timer_flags_2[7] && timer_int_mask_2[7]) |-> irq_req)
    else $error("overflow interrupt missing");
  prio_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (irq_source == 2'h0 && irq_req) |-> !(|(st_reg.icf_reg & {ic_en[0], ic_en[1], ic_en[2]})))
    else $error("overflow vectored over capture");

  // overflow flag: a one clears it, otherwise it holds
  tof_clr_one_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && tof_clr && !wrap) |=> !timer_flags_2[7])
    else $error("overflow flag not cleared by one write");

  tof_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && st_reg.tof_reg && !tof_clr) |=> st_reg.tof_reg)
    else $error("overflow flag dropped without clear");

  // clock enable low freezes every state bit
  state_freeze_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!ce) |=> $stable(st_reg))
    else $error("state moved while clock enable low");

  // no request when nothing enabled is pending
  irq_idle_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!(|(st_reg.icf_reg & {ic_en[0], ic_en[1], ic_en[2]}))
      && !(st_reg.tof_reg && timer_int_mask_2[7])) |-> !irq_req)
    else $error("interrupt request with nothing pending");

  // overflow alone vectors to source zero
  tof_source_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!(|(st_reg.icf_reg & {ic_en[0], ic_en[1], ic_en[2]}))
      && st_reg.tof_reg && timer_int_mask_2[7]) |-> (irq_req && irq_source == 2'h0))
    else $error("overflow request has wrong source");

  // every channel obeys the same flag and latch rules
  generate
    for (gi = 0; gi < `ICOT_NUM_IC; gi = gi + 1) begin : g_ic_chk
      ch_flag_set_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && hit[gi]) |=> timer_flags_1[`ICOT_CAPTURE1_FLAG_BIT-gi])
        else $error("capture flag not set on edge");

      ch_flag_clr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && ic_clr[gi] && !hit[gi]) |=> !timer_flags_1[`ICOT_CAPTURE1_FLAG_BIT-gi])
        else $error("capture flag not cleared by write");

      ch_flag_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && !ic_clr[gi] && timer_flags_1[`ICOT_CAPTURE1_FLAG_BIT-gi])
          |=> timer_flags_1[`ICOT_CAPTURE1_FLAG_BIT-gi])
        else $error("capture flag lost without clear");

      ch_value_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && hit[gi]) |=> (cap[gi] == $past(timer_count)))
        else $error("captured value differs from counter");

      ch_keep_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && !hit[gi]) |=> $stable(cap[gi]))
        else $error("captured value moved without edge");

      ch_count_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && hit[gi] && tick) |=> (timer_count == $past(timer_count) + 16'h0001))
        else $error("counter disturbed by capture");
    end
  endgenerate
endmodule
`default_nettype wire

// file: src/icot_map.svh
// constants for the input capture and overflow timer
`ifndef ICOT_MAP_SVH
`define ICOT_MAP_SVH
`define ICOT_CNT_W        16
`define ICOT_CNT_RST      16'h0000
`define ICOT_CNT_MAX      16'hffff
`define ICOT_CNT_ONE      16'h0001
`define ICOT_NUM_IC       3
`define ICOT_NUM_OC       5
`define ICOT_TOF_BIT      7
`define ICOT_CAPTURE1_FLAG_BIT     2
`define ICOT_IC1_MASK_BIT 2
`define ICOT_TOI_BIT      7
`define ICOT_EDG1_HI_BIT  5
`define ICOT_EDG1_LO_BIT  4
`define ICOT_TIMER_NS     500
`define ICOT_CLK_NS       20
`define ICOT_PRESCALE     1
`define ICOT_TICK_CYC     (`ICOT_TIMER_NS / `ICOT_CLK_NS)
`define ICOT_TICK_W       5
`define ICOT_IC_LOW_BIT   0
`define ICOT_ICF_RST      8'h00
`endif

// file: src/icot_pkg.sv
// types for the input capture and overflow timer
package icot_pkg;
  typedef enum logic [1:0] {
    ICOT_EDGE_OFF,
    ICOT_EDGE_RISE,
    ICOT_EDGE_FALL,
    ICOT_EDGE_ANY
  } icot_edge_t;

  typedef struct packed {
    logic [4:0]  tick_reg;
    logic [15:0] count_reg;
    logic        tof_reg;
    logic [2:0]  icf_reg;
    logic [2:0]  pin_reg;
  } icot_state_t;
endpackage

// file: src/icot_capture_ch.sv
// one input capture channel: edge detect, latch and flag-set hit pulse
`timescale 1ns/10ps
`default_nettype none
`include "icot_map.svh"
module icot_capture_ch (
  input  wire logic                   clk_sys,
  input  wire logic                   nrst,
  input  wire logic                   ce,
  input  wire logic [1:0]             edge_sel,
  input  wire logic                   pin_now,
  input  wire logic                   pin_prev,
  input  wire logic [`ICOT_CNT_W-1:0] count,
  output logic                        hit,
  output logic [`ICOT_CNT_W-1:0]      capture_value
);
  logic                   rise;
  logic                   fall;
  logic [`ICOT_CNT_W-1:0] cap_reg;
  logic [`ICOT_CNT_W-1:0] cap_next;

  assign rise = pin_now & ~pin_prev;
  assign fall = ~pin_now & pin_prev;

  always_comb begin
    case (icot_pkg::icot_edge_t'(edge_sel))
      icot_pkg::ICOT_EDGE_RISE: hit = rise;
      icot_pkg::ICOT_EDGE_FALL: hit = fall;
      icot_pkg::ICOT_EDGE_ANY:  hit = rise | fall;
      default:                  hit = 1'b0;
    endcase
    cap_next = hit ? count : cap_reg;
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cap_reg <= `ICOT_CNT_RST;
    end else if (ce) begin
      cap_reg <= cap_next;
    end
  end

  assign capture_value = cap_reg;

  cap_latch_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ce && hit) |=> (cap_reg == $past(count)))
    else $error("capture value does not match counter at edge");
endmodule
`default_nettype wire

// file: sim/icot_sig_src.sv
// far-side signal source driving the three capture pins
`timescale 1ns/10ps
`default_nettype none
module icot_sig_src (
  input  wire logic       clk_sys,
  input  wire logic [2:0] want,
  output logic      [2:0] capture_pin = 3'h0
);
  // levels move only just after a clock edge
  always @(posedge clk_sys) begin
    capture_pin <= want;
  end
endmodule
`default_nettype wire

// file: sim/input_capture_overflow_timer_tb_top.sv
// self-checking bench for the input capture and overflow timer
`timescale 1ns/10ps
`default_nettype none
`include "icot_map.svh"
module input_capture_overflow_timer_tb_top;
  logic        clk_sys = 1'b0;
  logic        nrst    = 1'b0;
  logic        f1_wr   = 1'b0;
  logic        f2_wr   = 1'b0;
  logic        ce      = 1'b1;
  logic [2:0]  want    = 3'h0;
  logic [2:0]  pins;
  logic [7:0]  ctl2    = 8'h00;
  logic [7:0]  msk1    = 8'h00;
  logic [7:0]  msk2    = 8'h00;
  logic [7:0]  f1_wd   = 8'h00;
  logic [15:0] cnt, cap1, cap2, cap3, c0;
  logic [7:0]  fl1, fl2;
  logic        irq;
  logic [1:0]  src;
  int          n_fail  = 0;
  int          num_checks = 0;
  // {edge pair, pin before, pin after, flag expected}
  logic [4:0]  rows [8] = '{5'h02, 5'h04, 5'h0b, 5'h0c, 5'h15, 5'h12, 5'h1b, 5'h1d};

  icot_sig_src SRC (.clk_sys(clk_sys), .want(want), .capture_pin(pins));
  icot_timer DUT (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .capture_pin(pins),
    .timer_control_2(ctl2), .timer_int_mask_1(msk1), .timer_int_mask_2(msk2),
    .flags_1_wr(f1_wr), .flags_1_wdata(f1_wd), .flags_2_wr(f2_wr),
    .flags_2_wdata(8'h80), .timer_count(cnt), .capture_value_1(cap1),
    .capture_value_2(cap2), .capture_value_3(cap3), .timer_flags_1(fl1),
    .timer_flags_2(fl2), .irq_req(irq), .irq_source(src));

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one-cycle clear write to flags 1, entered just after an edge
  task automatic clr1(input logic [7:0] d);
    f1_wd <= d;
    f1_wr <= 1'b1;
    cyc(1);
    f1_wr <= 1'b0;
  endtask

  // wait until the counter steps, leaving us at the falling edge after it
  task automatic tick_sync;
    c0 = cnt;
    for (int k = 0; k < 30 && cnt === c0; k++) @(negedge clk_sys);
    c0 = cnt;
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    cyc(8);
    nrst <= 1'b1;
    @(negedge clk_sys);
    chk({fl1, fl2}, 16'h0000);
    chk({cap1 | cap2 | cap3}, 16'h0000);
    foreach (rows[i]) begin
      @(posedge clk_sys);
      ctl2 <= {2'b00, rows[i][4:3], 4'h0};
      want <= {2'b00, rows[i][2]};
      cyc(4);
      clr1(8'h07);
      want <= {2'b00, rows[i][1]};
      cyc(3);
      @(negedge clk_sys);
      chk({15'h0, fl1[2]}, {15'h0, rows[i][0]});
    end
    @(posedge clk_sys);
    ctl2 <= 8'h1f;
    want <= 3'h0;
    msk1 <= 8'h07;
    msk2 <= 8'h80;
    cyc(4);
    clr1(8'h07);
    tick_sync;
    @(posedge clk_sys);
    want <= 3'h7;
    cyc(2);
    @(negedge clk_sys);
    chk({8'h0, fl1}, 16'h0007);
    chk(cap1 | (cap2 ^ c0) | (cap3 ^ c0), c0);
    chk({13'h0, irq, src}, 16'h0005);
    @(posedge clk_sys);
    clr1(8'hfb);
    @(negedge clk_sys);
    chk({8'h0, fl1}, 16'h0004);
    @(posedge clk_sys);
    clr1(8'h04);
    @(negedge clk_sys);
    chk({15'h0, irq}, 16'h0000);
    @(posedge clk_sys);
    msk1 <= 8'h01;
    want <= 3'h0;
    cyc(3);
    @(negedge clk_sys);
    chk({5'h0, fl1, irq, src}, 16'h001f);
    @(posedge clk_sys);
    msk1 <= 8'h00;
    f2_wr <= 1'b1;
    cyc(1);
    f2_wr <= 1'b0;
    @(negedge clk_sys);
    chk({7'h0, fl2, irq}, 16'h0000);
    tick_sync;
    cyc(24);
    @(negedge clk_sys);
    chk(cnt, c0);
    cyc(1);
    @(negedge clk_sys);
    chk(cnt, c0 + `ICOT_CNT_ONE);
    @(posedge clk_sys);
    ce <= 1'b0;
    want <= 3'h7;
    cyc(30);
    @(negedge clk_sys);
    chk({8'h0, fl1}, 16'h0003);
    chk(cnt, c0 + `ICOT_CNT_ONE);
    @(posedge clk_sys);
    ce <= 1'b1;
    cyc(2);
    @(negedge clk_sys);
    chk({8'h0, fl1}, 16'h0007);
    tally_and_finish;
  end

  initial begin
    #(20 * 3000);
    n_fail++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
